//--- bench/iss_core_model.sv
// Purpose: Behavioural core that turns bench requests into one-cycle commands.
// Assumes: The bench raises op for one cycle and only while irq_ack is low.
// Notes: The pc field always carries pc_in, so a grant pushes the bench's address.
`timescale 1ns/1ps
`default_nettype none

module iss_core_model
	import iss_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Bench request: 1 call, 2 plain return, 3 interrupt return.
	input wire logic [1:0] op,
	input wire logic [11:0] pc_in,
	// Sequencer side.
	input wire logic irq_ack,
	output var iss_core_cmd_t core_cmd
);
	// A request sampled in a granting cycle is dropped, so the cycle after a grant carries no command.
	always_ff @(posedge clk) begin
		core_cmd.pc <= pc_in;
		core_cmd.call <= !rst && !irq_ack && op == 2'h1;
		core_cmd.plain_return <= !rst && !irq_ack && op == 2'h2;
		core_cmd.return_from_interrupt <= !rst && !irq_ack && op == 2'h3;
	end
endmodule : iss_core_model
`default_nettype wire

//--- bench/tb_interrupt_stack_sequencer.sv
// Purpose: Self-checking bench for the interrupt and return-stack sequencer.
// Assumes: Inputs change by non-blocking assignment on the rising edge.
// Notes: Outputs are sampled on the falling edge, once every update has landed.
`timescale 1ns/1ps
`default_nettype none

module tb_interrupt_stack_sequencer
	import iss_pkg::*;
;
	logic clk, rst, rise;
	logic [1:0] op;
	logic [11:0] pc_in, irq_vector, return_pc;
	logic [5:0] ev; // One event per source, in priority order.
	logic [2:0] grp; // Which group-zero pins take part.
	iss_core_cmd_t core_cmd;
	iss_mem_req_t mem_req;
	logic irq_ack, return_valid, mem_hit, wake_request;
	logic [7:0] mem_rdata;
	int errors, compares, seed, i, j;
	logic [11:0] pcs [0:8];

	iss_core_model core (.clk(clk), .rst(rst), .op(op), .pc_in(pc_in), .irq_ack(irq_ack),
		.core_cmd(core_cmd));
	// External pins idle at the level opposite to the selected edge.
	iss_sequencer dut (.clk(clk), .rst(rst), .core_cmd(core_cmd), .irq_ack(irq_ack),
		.irq_vector(irq_vector), .return_pc(return_pc), .return_valid(return_valid),
		.mem_req(mem_req), .mem_rdata(mem_rdata), .mem_hit(mem_hit), .comparator_out(~ev[0]),
		.ext_group_zero_input_a(rise ~^ (ev[1] & grp[0])),
		.ext_group_zero_input_b(rise ~^ (ev[1] & grp[1])),
		.ext_group_zero_input_c(rise ~^ (ev[1] & grp[2])), .ext_input_one(rise ~^ ev[2]),
		.ext_rising_select(rise), .pwm_period_event(ev[3]), .timer_zero_overflow(ev[4]),
		.timer_one_overflow(ev[5]), .wake_request(wake_request));

	// Free-running 250 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Expected vector of a source: four words apart, starting at 004.
	function automatic logic [11:0] vec(input int s);
		return 12'(4 * (s + 1));
	endfunction : vec
	// Enables of the first register: global, plus the source's own bit for the first three sources.
	function automatic logic [7:0] en1(input int s);
		return (s < 3) ? 8'h01 | (8'h02 << s) : 8'h01;
	endfunction : en1
	// Enables of the second register for the last three sources.
	function automatic logic [7:0] en2(input int s);
		return (s >= 3) ? 8'h01 << (s - 3) : 8'h00;
	endfunction : en2

	// Verdict; also the landing place of any wait that runs out.
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	// Four-state comparison, so an unknown never matches.
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Read returns one cycle after the address is presented.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) mem_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk);
		@(negedge clk) chk({4'h0, mem_rdata}, {4'h0, e});
		chk({11'h0, mem_hit},
			{11'h0, a == ISS_ADDR_CTRL_FIRST || a == ISS_ADDR_CTRL_SECOND});
	endtask : rd
	// One-cycle write strobe.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) mem_req <= '{wr: 1'b1, addr: a, wdata: d};
		@(posedge clk) mem_req.wr <= 1'b0;
	endtask : wr
	// Core command; ends where a return's result is visible.
	task automatic cmd(input logic [1:0] o, input logic [11:0] p);
		@(posedge clk) op <= o;
		pc_in <= p;
		@(posedge clk) op <= 2'h0;
		@(posedge clk);
		@(negedge clk) chk({11'h0, return_valid}, {11'h0, o != 2'h1});
	endtask : cmd
	// One-cycle event on a source.
	task automatic fire(input int s);
		@(posedge clk) ev[s] <= 1'b1;
		@(posedge clk) ev[s] <= 1'b0;
	endtask : fire
	// Bounded wait for a grant, then the vector is checked.
	task automatic wait_ack(input logic [11:0] v);
		int k;
		for (k = 0; k < 20 && irq_ack !== 1'b1; k++) @(negedge clk);
		if (k == 20) begin
			errors++;
			results();
		end else begin
			chk(irq_vector, v);
		end
	endtask : wait_ack

	initial begin
		seed = 32'hbe4d;
		rst = 1'b1;
		op = 2'h0;
		pc_in = 12'h000;
		ev = 6'h00;
		grp = 3'h1;
		rise = 1'b1;
		mem_req = '0;
		errors = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(ISS_ADDR_CTRL_FIRST, ISS_CTRL_RESET);
		rd(ISS_ADDR_CTRL_SECOND, ISS_CTRL_RESET);
		rd(8'h0a, 8'h00);
		// Each source alone; group zero sees a rising edge, input one a falling edge.
		for (i = 0; i < ISS_NSRC; i++) begin
			@(posedge clk) rise <= (i < 3) ? i[0] : 1'($random(seed));
			grp <= 3'h1 << ($unsigned($random(seed)) % 3);
			pcs[0] = 12'($random(seed));
			pc_in <= pcs[0];
			// Pin idle levels just moved; the writes below clear any stray flag.
			repeat (3) @(posedge clk);
			wr(ISS_ADDR_CTRL_SECOND, en2(i));
			wr(ISS_ADDR_CTRL_FIRST, en1(i));
			fire(i);
			wait_ack(vec(i));
			rd(ISS_ADDR_CTRL_FIRST, en1(i) & 8'hfe);
			rd(ISS_ADDR_CTRL_SECOND, en2(i));
			cmd(2'h3, pcs[0]);
			chk(return_pc, pcs[0]);
			rd(ISS_ADDR_CTRL_FIRST, en1(i));
			$display("Test source %0d done", i);
		end
		// All six pending at once, global off, then served in order with nesting.
		wr(ISS_ADDR_CTRL_SECOND, 8'h07);
		wr(ISS_ADDR_CTRL_FIRST, 8'h0e);
		for (i = 0; i < ISS_NSRC; i++) fire(i);
		@(negedge clk) chk({11'h0, wake_request}, 12'h001);
		chk({11'h0, irq_ack}, 12'h000);
		chk(irq_vector, ISS_PC_RESET);
		for (i = 0; i < ISS_NSRC; i++) begin
			wr(ISS_ADDR_CTRL_FIRST, 8'h7f);
			wait_ack(vec(i));
		end
		rd(ISS_ADDR_CTRL_FIRST, 8'h0e);
		// A pending flag stays until software writes a zero over it.
		fire(5);
		rd(ISS_ADDR_CTRL_SECOND, 8'h47);
		wr(ISS_ADDR_CTRL_SECOND, 8'h07);
		rd(ISS_ADDR_CTRL_SECOND, 8'h07);
		$display("Test priority done");
		// Mid-run reset, then nine calls overflow the stack.
		@(posedge clk) rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (j = 0; j < 9; j++) begin
			pcs[j] = 12'($random(seed));
			cmd(2'h1, pcs[j]);
		end
		wr(ISS_ADDR_CTRL_SECOND, 8'h02);
		wr(ISS_ADDR_CTRL_FIRST, 8'h01);
		fire(4);
		for (j = 0; j < 5; j++) @(negedge clk) chk({11'h0, irq_ack}, 12'h000);
		rd(ISS_ADDR_CTRL_SECOND, 8'h22);
		cmd(2'h2, 12'h0ff);
		chk(return_pc, pcs[8]);
		wait_ack(ISS_VEC_TMR0);
		// The grant pushed 0ff; the oldest call was lost.
		for (j = 8; j > 0; j--) begin
			cmd(2'h2, 12'h0ff);
			chk(return_pc, (j == 8) ? 12'h0ff : pcs[j]);
		end
		rd(ISS_ADDR_CTRL_FIRST, 8'h00);
		$display("Test stack overflow done");
		results();
	end
endmodule : tb_interrupt_stack_sequencer
`default_nettype wire

//--- rtl/iss_sequencer.sv
// Purpose: Interrupt flags, enables, priority vectoring and the 8-level return stack.
// Assumes: One instruction sample per clock; core issues no call or return while ack is high.
// Notes: Status and other registers are never saved; software keeps them.
//
// Contract
// - Eight-level stack, program counter only, hidden.
// - Push program counter on call and acknowledgment.
// - Return pops stack and reloads program counter.
// - Reset leaves stack level pointer empty.
// - Full stack withholds acknowledgment, flags still set.
// - Call on full stack drops oldest entry.
// - Acknowledgment clears global enable; flags keep setting.
// - Nesting when enables set again, stack free.
// - Any source request wakes halted device.
// - Only program counter saved on entry.
// - Comparator falling edge sets comparator flag.
// - Comparator vectors 04H, clears flag, global enable.
// - External edges, selectable polarity, flags bits 5,6.
// - External vectors 08H or 0CH, clear flags.
// - PWM period sets bit 4, vectors 10H.
// - Timer zero sets bit 5, vectors 14H.
// - Timer one sets bit 6, vectors 18H.
// - Control registers at 0BH and 1EH.
// - Fixed priority comparator first, timer one last.
// - Interrupt return sets global enable; plain return not.
// - First register bits 0-3 are enables.
// - Flags stay set until serviced or cleared.
`timescale 1ns/1ps
`default_nettype none

module iss_sequencer
	import iss_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Core instruction stream.
	input wire iss_core_cmd_t core_cmd,
	output logic irq_ack,
	output logic [11:0] irq_vector,
	output logic [11:0] return_pc,
	output logic return_valid,
	// Data-memory access to the control registers.
	input wire iss_mem_req_t mem_req,
	output logic [7:0] mem_rdata,
	output logic mem_hit,
	// Event sources.
	input wire logic comparator_out,
	input wire logic ext_group_zero_input_a,
	input wire logic ext_group_zero_input_b,
	input wire logic ext_group_zero_input_c,
	input wire logic ext_input_one,
	input wire logic ext_rising_select,
	input wire logic pwm_period_event,
	input wire logic timer_zero_overflow,
	input wire logic timer_one_overflow,
	// Power management.
	output logic wake_request
);

	// Returns the vector for a source index in priority order.
	function automatic logic [11:0] iss_vector(input int idx);
		case (idx)
			0: iss_vector = ISS_VEC_CMP;
			1: iss_vector = ISS_VEC_EXT0;
			2: iss_vector = ISS_VEC_EXT1;
			3: iss_vector = ISS_VEC_PWM;
			4: iss_vector = ISS_VEC_TMR0;
			default: iss_vector = ISS_VEC_TMR1;
		endcase
	endfunction : iss_vector

	// Stack storage and level pointer; neither is visible to software.
	logic [11:0] stack_mem [ISS_STACK_DEPTH];
	logic [3:0] stack_level_pointer;
	logic [2:0] stack_top_idx;

	// Enable bits of both control registers.
	logic global_irq_enable;
	logic comparator_irq_enable;
	logic ext_group_zero_enable;
	logic ext_input_one_enable;
	logic pwm_period_enable;
	logic timer_zero_enable;
	logic timer_one_enable;

	// Sticky request flags, priority order.
	logic [ISS_NSRC-1:0] req_flag;
	logic [ISS_NSRC-1:0] src_enable;
	logic [ISS_NSRC-1:0] src_event;
	logic [ISS_NSRC-1:0] clr_by_sw;
	logic [ISS_NSRC-1:0] grant;

	// Previous input levels for edge detection.
	logic cmp_prev;
	logic [3:0] ext_prev;
	logic [3:0] ext_now;
	logic [3:0] ext_edge;

	// Decoded register writes.
	logic wr_first;
	logic wr_second;
	logic stack_full;
	logic do_ret;

	assign stack_full = (stack_level_pointer == ISS_LEVEL_FULL);
	assign wr_first = mem_req.wr && (mem_req.addr == ISS_ADDR_CTRL_FIRST);
	assign wr_second = mem_req.wr && (mem_req.addr == ISS_ADDR_CTRL_SECOND);
	assign do_ret = core_cmd.plain_return || core_cmd.return_from_interrupt;
	assign src_enable = {timer_one_enable, timer_zero_enable, pwm_period_enable,
		ext_input_one_enable, ext_group_zero_enable, comparator_irq_enable};

	// Edge detection on the sampled pins; polarity chosen by the ext_rising_select input.
	assign ext_now = {ext_input_one, ext_group_zero_input_c, ext_group_zero_input_b,
		ext_group_zero_input_a};
	assign ext_edge = ext_rising_select ? (ext_now & ~ext_prev) : (~ext_now & ext_prev);
	assign src_event[0] = cmp_prev && !comparator_out;
	assign src_event[1] = |ext_edge[2:0];
	assign src_event[2] = ext_edge[3];
	assign src_event[3] = pwm_period_event;
	assign src_event[4] = timer_zero_overflow;
	assign src_event[5] = timer_one_overflow;

	// Software clear: a write that puts a zero in a flag bit.
	assign clr_by_sw[0] = wr_first && !mem_req.wdata[ISS_B_CMP_FLAG];
	assign clr_by_sw[1] = wr_first && !mem_req.wdata[ISS_B_EXT0_FLAG];
	assign clr_by_sw[2] = wr_first && !mem_req.wdata[ISS_B_EXT1_FLAG];
	assign clr_by_sw[3] = wr_second && !mem_req.wdata[ISS_B_PWM_FLAG];
	assign clr_by_sw[4] = wr_second && !mem_req.wdata[ISS_B_TMR0_FLAG];
	assign clr_by_sw[5] = wr_second && !mem_req.wdata[ISS_B_TMR1_FLAG];

	// Fixed priority grant; the full stack holds back every acknowledgment.
	always_comb begin
		grant = '0;
		irq_ack = 1'b0;
		irq_vector = ISS_PC_RESET;
		if (global_irq_enable && !stack_full && !do_ret) begin
			for (int i = ISS_NSRC - 1; i >= 0; i--) begin
				if (req_flag[i] && src_enable[i]) begin
					grant = '0;
					grant[i] = 1'b1;
					irq_vector = iss_vector(i);
				end
			end
			irq_ack = |grant;
		end
	end

	// Any pending flag wakes the halted core, whatever the enables.
	assign wake_request = |req_flag;

	// Edge history registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_prev <= 1'b0;
			ext_prev <= 4'h0;
		end else begin
			cmp_prev <= comparator_out;
			ext_prev <= ext_now;
		end
	end

	// Request flags: event sets win over software clear and over service.
	always_ff @(posedge clk) begin
		if (rst) begin
			req_flag <= '0;
		end else begin
			for (int i = 0; i < ISS_NSRC; i++) begin
				if (src_event[i]) begin
					req_flag[i] <= 1'b1;
				end else if (grant[i] || clr_by_sw[i]) begin
					req_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Enable bits; acknowledgment and return-from-interrupt own the global bit.
	always_ff @(posedge clk) begin
		if (rst) begin
			global_irq_enable <= 1'b0;
			comparator_irq_enable <= 1'b0;
			ext_group_zero_enable <= 1'b0;
			ext_input_one_enable <= 1'b0;
			pwm_period_enable <= 1'b0;
			timer_zero_enable <= 1'b0;
			timer_one_enable <= 1'b0;
		end else begin
			if (wr_first) begin
				global_irq_enable <= mem_req.wdata[ISS_B_GLOBAL_EN];
				comparator_irq_enable <= mem_req.wdata[ISS_B_CMP_EN];
				ext_group_zero_enable <= mem_req.wdata[ISS_B_EXT0_EN];
				ext_input_one_enable <= mem_req.wdata[ISS_B_EXT1_EN];
			end
			if (wr_second) begin
				pwm_period_enable <= mem_req.wdata[ISS_B_PWM_EN];
				timer_zero_enable <= mem_req.wdata[ISS_B_TMR0_EN];
				timer_one_enable <= mem_req.wdata[ISS_B_TMR1_EN];
			end
			if (irq_ack) begin
				global_irq_enable <= 1'b0;
			end else if (core_cmd.return_from_interrupt) begin
				global_irq_enable <= 1'b1;
			end
		end
	end

	// The stack is a circular buffer: a call at full overwrites the oldest slot.
	assign stack_top_idx = 3'(stack_level_pointer - 4'h1);
	always_ff @(posedge clk) begin
		if (rst) begin
			stack_level_pointer <= ISS_LEVEL_EMPTY;
		end else if (irq_ack || core_cmd.call) begin
			if (!stack_full) begin
				stack_level_pointer <= stack_level_pointer + 4'h1;
			end
		end else if (do_ret && stack_level_pointer != ISS_LEVEL_EMPTY) begin
			stack_level_pointer <= stack_level_pointer - 4'h1;
		end
	end

	// Ring base rotates on overflow so only the newest eight survive.
	logic [2:0] ring_base;
	logic [2:0] push_slot;
	assign push_slot = 3'(ring_base + stack_level_pointer[2:0]);
	always_ff @(posedge clk) begin
		if (rst) begin
			ring_base <= 3'h0;
		end else if ((irq_ack || core_cmd.call) && stack_full) begin
			ring_base <= ring_base + 3'h1;
		end
	end

	// Only the program counter is stored; nothing else is saved.
	always_ff @(posedge clk) begin
		if (irq_ack || core_cmd.call) begin
			stack_mem[push_slot] <= core_cmd.pc;
		end
	end

	// Popped address registered for the core.
	always_ff @(posedge clk) begin
		if (rst) begin
			return_pc <= ISS_PC_RESET;
			return_valid <= 1'b0;
		end else begin
			return_valid <= do_ret && !irq_ack;
			if (do_ret) begin
				return_pc <= stack_mem[3'(ring_base + stack_top_idx)];
			end
		end
	end

	// Read-back of both control registers; unused bits read zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_rdata <= ISS_CTRL_RESET;
			mem_hit <= 1'b0;
		end else begin
			mem_hit <= (mem_req.addr == ISS_ADDR_CTRL_FIRST) ||
				(mem_req.addr == ISS_ADDR_CTRL_SECOND);
			if (mem_req.addr == ISS_ADDR_CTRL_FIRST) begin
				mem_rdata <= {1'b0, req_flag[2:0], ext_input_one_enable,
					ext_group_zero_enable, comparator_irq_enable, global_irq_enable};
			end else if (mem_req.addr == ISS_ADDR_CTRL_SECOND) begin
				mem_rdata <= {1'b0, req_flag[5:3], 1'b0, timer_one_enable,
					timer_zero_enable, pwm_period_enable};
			end else begin
				mem_rdata <= ISS_CTRL_RESET;
			end
		end
	end

	// Acknowledge only with all three conditions present.
	a_ack_needs_enable: assert property (@(posedge clk) disable iff (rst)
		irq_ack |-> global_irq_enable && !stack_full && (|(req_flag & src_enable)))
		else $error("ack without enable");
	a_ack_clears_global: assert property (@(posedge clk) disable iff (rst)
		irq_ack |=> !global_irq_enable) else $error("global enable kept after ack");
	a_full_blocks_ack: assert property (@(posedge clk) disable iff (rst)
		stack_full |-> !irq_ack) else $error("ack with full stack");
	a_push_grows_level: assert property (@(posedge clk) disable iff (rst)
		(core_cmd.call && !stack_full) |=> stack_level_pointer == $past(stack_level_pointer) + 4'h1)
		else $error("push did not grow level");
	a_return_from_interrupt_sets_global: assert property (@(posedge clk) disable iff (rst)
		(core_cmd.return_from_interrupt && !irq_ack && !wr_first) |=> global_irq_enable)
		else $error("interrupt return left global off");
	a_cmp_edge_flag: assert property (@(posedge clk) disable iff (rst)
		src_event[0] |=> req_flag[0]) else $error("comparator edge lost");
	a_cmp_top_priority: assert property (@(posedge clk) disable iff (rst)
		(irq_ack && req_flag[0] && comparator_irq_enable) |-> irq_vector == ISS_VEC_CMP)
		else $error("comparator not first");
	a_level_bounded: assert property (@(posedge clk) disable iff (rst)
		stack_level_pointer <= ISS_LEVEL_FULL) else $error("level beyond eight");

	// A call at full keeps eight levels and moves the ring base past the lost entry.
	a_full_call_level: assert property (@(posedge clk) disable iff (rst)
		(core_cmd.call && stack_full) |=> stack_full && ring_base == $past(ring_base) + 3'h1)
		else $error("overflow call did not rotate the ring");
	a_return_pops: assert property (@(posedge clk) disable iff (rst)
		(do_ret && !core_cmd.call && stack_level_pointer != ISS_LEVEL_EMPTY)
		|=> stack_level_pointer == $past(stack_level_pointer) - 4'h1)
		else $error("return did not pop level");
	a_grant_clears_flag: assert property (@(posedge clk) disable iff (rst)
		(grant[0] && !src_event[0]) |=> !req_flag[0]) else $error("serviced flag kept");

endmodule : iss_sequencer

`default_nettype wire

//--- shared/iss_pkg.sv
// Purpose: Shared constants and types for the interrupt and return-stack sequencer.
// Assumes: Data memory addresses are 8 bits, program counter is 12 bits.
// Notes: Every offset, field position and vector lives here.
package iss_pkg;

	// Register locations in data memory.
	localparam logic [7:0] ISS_ADDR_CTRL_FIRST = 8'h0b;
	localparam logic [7:0] ISS_ADDR_CTRL_SECOND = 8'h1e;

	// Field positions in the first control register.
	localparam int ISS_B_GLOBAL_EN = 0;
	localparam int ISS_B_CMP_EN = 1;
	localparam int ISS_B_EXT0_EN = 2;
	localparam int ISS_B_EXT1_EN = 3;
	localparam int ISS_B_CMP_FLAG = 4;
	localparam int ISS_B_EXT0_FLAG = 5;
	localparam int ISS_B_EXT1_FLAG = 6;

	// Field positions in the second control register.
	localparam int ISS_B_PWM_EN = 0;
	localparam int ISS_B_TMR0_EN = 1;
	localparam int ISS_B_TMR1_EN = 2;
	localparam int ISS_B_PWM_FLAG = 4;
	localparam int ISS_B_TMR0_FLAG = 5;
	localparam int ISS_B_TMR1_FLAG = 6;

	// Stack geometry and reset values.
	localparam int ISS_STACK_DEPTH = 8;
	localparam logic [3:0] ISS_LEVEL_EMPTY = 4'h0;
	localparam logic [3:0] ISS_LEVEL_FULL = 4'h8;
	localparam logic [7:0] ISS_CTRL_RESET = 8'h00;
	localparam logic [11:0] ISS_PC_RESET = 12'h000;

	// Source count, in priority order (index 0 served first).
	localparam int ISS_NSRC = 6;

	// Vectors for each source in priority order.
	localparam logic [11:0] ISS_VEC_CMP = 12'h004;
	localparam logic [11:0] ISS_VEC_EXT0 = 12'h008;
	localparam logic [11:0] ISS_VEC_EXT1 = 12'h00c;
	localparam logic [11:0] ISS_VEC_PWM = 12'h010;
	localparam logic [11:0] ISS_VEC_TMR0 = 12'h014;
	localparam logic [11:0] ISS_VEC_TMR1 = 12'h018;

	// Core instruction command carried each cycle.
	typedef struct packed {
		logic call;
		logic plain_return;
		logic return_from_interrupt;
		logic [11:0] pc;
	} iss_core_cmd_t;

	// Data-memory access from the core.
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iss_mem_req_t;

endpackage : iss_pkg
